// File: verilog/fifo_ports.v
// Decided for this implementation: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "fifo_ports_defines.vh"

module fifo_ports
(
    input  wire        CLK,
    input  wire        RSTN,
    input  wire [7:0]  AWADDR,
    input  wire        AWVALID,
    output wire        AWREADY,
    input  wire [31:0] WDATA,
    input  wire [3:0]  WSTRB,
    input  wire        WVALID,
    output wire        WREADY,
    output wire [1:0]  BRESP,
    output wire        BVALID,
    input  wire        BREADY,
    input  wire [7:0]  ARADDR,
    input  wire        ARVALID,
    output wire        ARREADY,
    output wire [31:0] RDATA,
    output wire [1:0]  RRESP,
    output wire        RVALID,
    input  wire        RREADY,
    input  wire        RESET,
    input  wire [31:0] WRITE_DATA,
    input  wire [3:0]  WRITE_PARITY_IN,
    input  wire        WRITE_REQUEST,
    input  wire        READ_REQUEST,
    output wire [31:0] READ_DATA,
    output wire [3:0]  READ_PARITY_OUT,
    output wire        EMPTY,
    output wire        FULL,
    output wire        ALMOST_EMPTY_FLAG,
    output wire        ALMOST_FULL_FLAG,
    output wire [12:0] READ_SIDE_COUNT,
    output wire        READ_ERROR,
    output wire        WRITE_ERROR,
    output wire        READ_RESET_BUSY,
    output wire        WRITE_RESET_BUSY,
    output wire        IRQ
);

    // ============================================================
    // Helpers
    // Mask of the used bits of a stored word for a width code
    function [35:0] width_mask;
        input [1:0] code;
        begin
            case (code)
                `WIDTH_36: width_mask = 36'hFFFFFFFFF;
                `WIDTH_18: width_mask = 36'h30000FFFF;
                `WIDTH_9:  width_mask = 36'h1000000FF;
                default:   width_mask = 36'h00000000F;
            endcase
        end
    endfunction

    // Byte-lane merge for register writes
    function [31:0] lane_merge;
        input [31:0] old_v;
        input [31:0] new_v;
        input [3:0]  strb;
        integer i;
        begin
            lane_merge = old_v;
            for (i = 0; i < 4; i = i + 1)
                if (strb[i])
                    lane_merge[i*8 +: 8] = new_v[i*8 +: 8];
        end
    endfunction

    // ============================================================
    // Declarations
    reg  [2:0]           ctrl_q;
    reg  [12:0]          ae_thr_q;
    reg  [12:0]          af_thr_q;
    reg  [3:0]           int_st_q;
    reg  [3:0]           int_mask_q;
    reg  [8:0]           wr_ptr_q;
    reg  [8:0]           rd_ptr_q;
    reg  [`CNT_W-1:0]    cnt_q;
    reg  [`CNT_W-1:0]    cnt_d;
    reg                  empty_q;
    reg                  full_q;
    reg                  ae_q;
    reg                  af_q;
    reg  [12:0]          rcount_q;
    reg                  rd_err_q;
    reg                  wr_err_q;
    reg                  busy_q;
    reg  [2:0]           busy_cnt_q;
    reg                  irq_q;
    reg                  awready_q;
    reg                  wready_q;
    reg                  aw_have_q;
    reg                  w_have_q;
    reg  [7:0]           aw_addr_q;
    reg  [31:0]          w_data_q;
    reg  [3:0]           w_strb_q;
    reg                  bvalid_q;
    reg  [1:0]           bresp_q;
    reg                  arready_q;
    reg                  rvalid_q;
    reg  [31:0]          rdata_q;
    reg  [1:0]           rresp_q;
    reg  [31:0]          rd_mux;
    reg                  rd_hit;
    wire                 wr_ok;
    wire                 rd_ok;
    wire                 reg_wr;
    wire [35:0]          store_out;
    wire [35:0]          mask;
    wire [3:0]           int_clr;
    wire [3:0]           int_ev;
    wire [31:0]          ctrl_wr;
    wire [31:0]          ae_wr;
    wire [31:0]          af_wr;
    wire [31:0]          imask_wr;

    // ============================================================
    // Request qualification
    assign mask   = width_mask(ctrl_q[`CTRL_WIDTH_HI:`CTRL_WIDTH_LO]);
    assign wr_ok  = WRITE_REQUEST && !full_q && !busy_q && !RESET;
    assign rd_ok  = READ_REQUEST && !empty_q && !busy_q && !RESET;
    assign reg_wr = aw_have_q && w_have_q && !bvalid_q;

    // Register values after a strobed write, cut to width where stored
    assign ctrl_wr  = lane_merge({29'h0, ctrl_q}, w_data_q, w_strb_q);
    assign ae_wr    = lane_merge({19'h0, ae_thr_q}, w_data_q, w_strb_q);
    assign af_wr    = lane_merge({19'h0, af_thr_q}, w_data_q, w_strb_q);
    assign imask_wr = lane_merge({28'h0, int_mask_q}, w_data_q, w_strb_q);

    // Word count after this cycle's accepted requests
    always @*
    begin
        cnt_d = cnt_q;
        if (wr_ok && !rd_ok)
            cnt_d = cnt_q + 10'h001;
        else if (rd_ok && !wr_ok)
            cnt_d = cnt_q - 10'h001;
    end

    // ============================================================
    // Storage array
    fifo_store u_store
    (
        .clk     (CLK),
        .rstn    (RSTN),
        .wr_en   (wr_ok),
        .wr_addr (wr_ptr_q),
        .wr_word ({WRITE_PARITY_IN, WRITE_DATA} & mask),
        .rd_en   (rd_ok),
        .rd_addr (rd_ptr_q),
        .rd_word (store_out)
    );

    // ============================================================
    // Reset busy: held through the reset and a short tail after it
    always @(posedge CLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            busy_q     <= 1'b1;
            busy_cnt_q <= `BUSY_CYCLES;
        end
        else if (RESET)
        begin
            busy_q     <= 1'b1;
            busy_cnt_q <= `BUSY_CYCLES;
        end
        else if (busy_cnt_q != 3'h0)
            busy_cnt_q <= busy_cnt_q - 3'h1;
        else
            busy_q     <= 1'b0;
    end

    // ============================================================
    // Pointers, count, flags and error pulses
    always @(posedge CLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            wr_ptr_q <= 9'h000;
            rd_ptr_q <= 9'h000;
            cnt_q    <= 10'h000;
            empty_q  <= 1'b1;
            full_q   <= 1'b0;
            ae_q     <= 1'b1;
            af_q     <= 1'b0;
            rcount_q <= 13'h0000;
            rd_err_q <= 1'b0;
            wr_err_q <= 1'b0;
        end
        else if (RESET)
        begin
            wr_ptr_q <= 9'h000;
            rd_ptr_q <= 9'h000;
            cnt_q    <= 10'h000;
            empty_q  <= 1'b1;
            full_q   <= 1'b0;
            ae_q     <= 1'b1;
            af_q     <= 1'b0;
            rcount_q <= 13'h0000;
            rd_err_q <= READ_REQUEST;
            wr_err_q <= WRITE_REQUEST;
        end
        else
        begin
            if (wr_ok)
                wr_ptr_q <= wr_ptr_q + 9'h001;
            if (rd_ok)
                rd_ptr_q <= rd_ptr_q + 9'h001;
            cnt_q    <= cnt_d;
            empty_q  <= (cnt_d == 10'h000);
            full_q   <= (cnt_d == `DEPTH);
            ae_q     <= ({3'h0, cnt_d} <= ae_thr_q);
            af_q     <= ({3'h0, cnt_d} >= af_thr_q);
            if (ctrl_q[`CTRL_CNT_SEL])
                rcount_q <= {3'h0, cnt_d};
            else if (rd_ok)
                rcount_q <= {4'h0, rd_ptr_q + 9'h001};
            else
                rcount_q <= {4'h0, rd_ptr_q};
            rd_err_q <= READ_REQUEST && !rd_ok;
            wr_err_q <= WRITE_REQUEST && !wr_ok;
        end
    end

    // ============================================================
    // Interrupt status, set wins over write-one-to-clear
    assign int_ev  = {ae_q, af_q, wr_err_q, rd_err_q};
    assign int_clr = (reg_wr && aw_addr_q == `OFS_INT_STATUS && w_strb_q[0]) ?
                     w_data_q[3:0] : 4'h0;

    always @(posedge CLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            int_st_q <= 4'h0;
            irq_q    <= 1'b0;
        end
        else
        begin
            int_st_q <= (int_st_q & ~int_clr) | int_ev;
            irq_q    <= |(((int_st_q & ~int_clr) | int_ev) & int_mask_q);
        end
    end

    // ============================================================
    // AXI write channels and register writes
    always @(posedge CLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            awready_q  <= 1'b1;
            wready_q   <= 1'b1;
            aw_have_q  <= 1'b0;
            w_have_q   <= 1'b0;
            aw_addr_q  <= 8'h00;
            w_data_q   <= 32'h00000000;
            w_strb_q   <= 4'h0;
            bvalid_q   <= 1'b0;
            bresp_q    <= `RESP_OKAY;
            ctrl_q     <= `CTRL_RESET;
            ae_thr_q   <= `AE_RESET;
            af_thr_q   <= `AF_RESET;
            int_mask_q <= 4'h0;
        end
        else
        begin
            if (AWVALID && awready_q)
            begin
                aw_addr_q <= AWADDR;
                aw_have_q <= 1'b1;
                awready_q <= 1'b0;
            end
            if (WVALID && wready_q)
            begin
                w_data_q <= WDATA;
                w_strb_q <= WSTRB;
                w_have_q <= 1'b1;
                wready_q <= 1'b0;
            end
            if (reg_wr)
            begin
                bvalid_q  <= 1'b1;
                bresp_q   <= `RESP_OKAY;
                aw_have_q <= 1'b0;
                w_have_q  <= 1'b0;
                case (aw_addr_q)
                    `OFS_CTRL:
                        ctrl_q <= ctrl_wr[2:0];
                    `OFS_AE_THRESH:
                        ae_thr_q <= ae_wr[12:0];
                    `OFS_AF_THRESH:
                        af_thr_q <= af_wr[12:0];
                    `OFS_INT_MASK:
                        int_mask_q <= imask_wr[3:0];
                    `OFS_STATUS, `OFS_INT_STATUS:
                        bresp_q <= `RESP_OKAY;
                    default:
                        bresp_q <= `RESP_SLVERR;
                endcase
            end
            if (bvalid_q && BREADY)
            begin
                bvalid_q  <= 1'b0;
                awready_q <= 1'b1;
                wready_q  <= 1'b1;
            end
        end
    end

    // ============================================================
    // Read mux
    always @*
    begin
        rd_hit = 1'b1;
        case (ARADDR)
            `OFS_CTRL:       rd_mux = {29'h0, ctrl_q};
            `OFS_AE_THRESH:  rd_mux = {19'h0, ae_thr_q};
            `OFS_AF_THRESH:  rd_mux = {19'h0, af_thr_q};
            `OFS_STATUS:     rd_mux = {3'h0, rcount_q, 10'h0, busy_q, ae_q, af_q,
                                       full_q, empty_q, 1'b0};
            `OFS_INT_STATUS: rd_mux = {28'h0, int_st_q};
            `OFS_INT_MASK:   rd_mux = {28'h0, int_mask_q};
            default:
            begin
                rd_mux = 32'h00000000;
                rd_hit = 1'b0;
            end
        endcase
    end

    // AXI read channels
    always @(posedge CLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            arready_q <= 1'b1;
            rvalid_q  <= 1'b0;
            rdata_q   <= 32'h00000000;
            rresp_q   <= `RESP_OKAY;
        end
        else if (ARVALID && arready_q)
        begin
            arready_q <= 1'b0;
            rvalid_q  <= 1'b1;
            rdata_q   <= rd_mux;
            rresp_q   <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
        end
        else if (rvalid_q && RREADY)
        begin
            rvalid_q  <= 1'b0;
            arready_q <= 1'b1;
        end
    end

    // ============================================================
    // Outputs
    assign AWREADY           = awready_q;
    assign WREADY            = wready_q;
    assign BVALID            = bvalid_q;
    assign BRESP             = bresp_q;
    assign ARREADY           = arready_q;
    assign RVALID            = rvalid_q;
    assign RDATA             = rdata_q;
    assign RRESP             = rresp_q;
    // Stored words are already masked, so the read port flop drives the pins
    assign READ_DATA         = store_out[31:0];
    assign READ_PARITY_OUT   = store_out[35:32];
    assign EMPTY             = empty_q;
    assign FULL              = full_q;
    assign ALMOST_EMPTY_FLAG = ae_q;
    assign ALMOST_FULL_FLAG  = af_q;
    assign READ_SIDE_COUNT   = rcount_q;
    assign READ_ERROR        = rd_err_q;
    assign WRITE_ERROR       = wr_err_q;
    assign READ_RESET_BUSY   = busy_q;
    assign WRITE_RESET_BUSY  = busy_q;
    assign IRQ               = irq_q;

endmodule // fifo_ports

// File: include/fifo_ports_defines.vh
`ifndef FIFO_PORTS_DEFINES_VH
`define FIFO_PORTS_DEFINES_VH

// ============================================================
// Storage geometry
`define DATA_W          32
`define PAR_W           4
`define WORD_W          36
`define ADDR_W          9
`define DEPTH           10'h200
`define CNT_W           10
`define RCNT_W          13

// ============================================================
// Reset busy stretch after the reset input drops
`define BUSY_CYCLES     3'h4

// ============================================================
// Register byte offsets
`define OFS_CTRL        8'h00
`define OFS_AE_THRESH   8'h04
`define OFS_AF_THRESH   8'h08
`define OFS_STATUS      8'h0C
`define OFS_INT_STATUS  8'h10
`define OFS_INT_MASK    8'h14

// ============================================================
// Control fields and reset values
`define CTRL_CNT_SEL    0
`define CTRL_WIDTH_LO   1
`define CTRL_WIDTH_HI   2
`define CTRL_RESET      3'h1
`define AE_RESET        13'h0004
`define AF_RESET        13'h01FC

// Width setting codes
`define WIDTH_36        2'h0
`define WIDTH_18        2'h1
`define WIDTH_9         2'h2
`define WIDTH_4         2'h3

// ============================================================
// Interrupt status bits
`define INT_RD_ERR      0
`define INT_WR_ERR      1
`define INT_AF          2
`define INT_AE          3
`define INT_W           4

// AXI responses
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2

`endif

// File: verilog/fifo_store.v
`timescale 1ns/1ps

// ============================================================
// Word array with one write port and one registered read port
module fifo_store
(
    input  wire        clk,
    input  wire        rstn,
    input  wire        wr_en,
    input  wire [8:0]  wr_addr,
    input  wire [35:0] wr_word,
    input  wire        rd_en,
    input  wire [8:0]  rd_addr,
    output reg  [35:0] rd_word
);

    reg [35:0] mem [0:511];

    // Write port, no reset on the array
    always @(posedge clk)
    begin
        if (wr_en)
            mem[wr_addr] <= wr_word;
    end

    // Read port, word held until the next read
    always @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            rd_word <= 36'h0;
        else if (rd_en)
            rd_word <= mem[rd_addr];
    end

endmodule // fifo_store

// File: verification/fifo_ports_properties.sv
`timescale 1ns/1ps
// ============================================================
// Port checker for the FIFO block
module fifo_ports_checker
(
    input wire        CLK,
    input wire        RSTN,
    input wire        RESET,
    input wire        WRITE_REQUEST,
    input wire        READ_REQUEST,
    input wire        EMPTY,
    input wire        FULL,
    input wire        ALMOST_EMPTY_FLAG,
    input wire        ALMOST_FULL_FLAG,
    input wire [12:0] READ_SIDE_COUNT,
    input wire        READ_ERROR,
    input wire        WRITE_ERROR,
    input wire        READ_RESET_BUSY
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RSTN);

    // Refused requests and their pulses
    a_rd_empty_err: assert property (EMPTY && READ_REQUEST |=> READ_ERROR)
        else $error("no read error on empty");
    a_wr_full_err: assert property (FULL && WRITE_REQUEST |=> WRITE_ERROR)
        else $error("no write error on full");
    a_busy_rd_err: assert property (READ_RESET_BUSY && READ_REQUEST |=> READ_ERROR)
        else $error("no read error while busy");
    a_err_one_req: assert property ((READ_ERROR |-> $past(READ_REQUEST))
        and (WRITE_ERROR |-> $past(WRITE_REQUEST)))
        else $error("error pulse without request");
    a_err_hold_cnt: assert property (READ_ERROR && !$past(WRITE_REQUEST)
        && !$past(RESET) |-> $stable(READ_SIDE_COUNT))
        else $error("failed read moved the count");

    // Reset behaviour
    a_rstn_busy: assert property ($rose(RSTN) |-> READ_RESET_BUSY[*4])
        else $error("busy dropped early after reset");
    a_sync_rst: assert property (RESET |=> READ_RESET_BUSY && EMPTY
        && READ_SIDE_COUNT == 13'h0000)
        else $error("sync reset did not clear");

    // Flag relations
    a_full_flags: assert property (FULL |-> ALMOST_FULL_FLAG && !EMPTY)
        else $error("full flags inconsistent");
    a_empty_flags: assert property (EMPTY |-> ALMOST_EMPTY_FLAG && !FULL)
        else $error("empty flags inconsistent");
    a_wr_lands: assert property (WRITE_REQUEST && !FULL && !READ_RESET_BUSY
        && !RESET |=> !EMPTY && !WRITE_ERROR)
        else $error("accepted write not stored");
endmodule // fifo_ports_checker

bind fifo_ports fifo_ports_checker i_chk
(
    .CLK(CLK), .RSTN(RSTN), .RESET(RESET), .WRITE_REQUEST(WRITE_REQUEST),
    .READ_REQUEST(READ_REQUEST), .EMPTY(EMPTY), .FULL(FULL),
    .ALMOST_EMPTY_FLAG(ALMOST_EMPTY_FLAG), .ALMOST_FULL_FLAG(ALMOST_FULL_FLAG),
    .READ_SIDE_COUNT(READ_SIDE_COUNT), .READ_ERROR(READ_ERROR),
    .WRITE_ERROR(WRITE_ERROR), .READ_RESET_BUSY(READ_RESET_BUSY)
);

// File: verification/fifo_user_model.sv
`timescale 1ns/1ps
// ============================================================
// Fabric logic on the write and read sides of the FIFO
module fifo_user_model
(
    input  wire        clk,
    output reg         write_request,
    output reg         read_request,
    output reg         reset,
    output reg  [31:0] write_data,
    output reg  [3:0]  write_parity
);
    // Idle levels at time zero
    initial
    begin
        write_request = 1'b0;
        read_request  = 1'b0;
        reset         = 1'b0;
        write_data    = 32'h00000000;
        write_parity  = 4'h0;
    end

    // Writes on consecutive edges, word i is base plus i
    task put_burst(input integer n, input [31:0] base, input [3:0] par);
        integer i;
        begin
            for (i = 0; i < n; i = i + 1)
            begin
                write_request <= 1'b1;
                write_data    <= base + i;
                write_parity  <= par ^ i[3:0];
                @(posedge clk);
            end
            write_request <= 1'b0;
            write_data    <= ~write_data; // No stale word once released
            write_parity  <= ~write_parity;
        end
    endtask

    // Reads on consecutive edges
    task take_burst(input integer n);
        integer i;
        begin
            for (i = 0; i < n; i = i + 1)
            begin
                read_request <= 1'b1;
                @(posedge clk);
            end
            read_request <= 1'b0;
        end
    endtask

    // One-cycle reset on the write clock
    task pulse_reset;
        begin
            reset <= 1'b1;
            @(posedge clk);
            reset <= 1'b0;
        end
    endtask
endmodule // fifo_user_model

// File: verification/tb_fifo_ports.sv
`timescale 1ns/1ps
// ============================================================
// Bench for the FIFO block
module tb_fifo_ports;
    reg         clk, rstn, awvalid, wvalid, bready, arvalid, rready, done;
    reg  [7:0]  awaddr, araddr;
    reg  [31:0] wdata, d;
    reg  [1:0]  r;
    reg  [3:0]  wstrb;
    wire        awready, wready, bvalid, arready, rvalid, irq;
    wire [1:0]  bresp, rresp;
    wire [31:0] rdata, read_data, write_data;
    wire [3:0]  read_parity_out, write_parity;
    wire [12:0] count;
    wire        write_request, read_request, reset, empty, full, ae, af;
    wire        read_error, write_error, busy, wbusy;
    integer     num_errors, samples_checked, c, n;

    // Design and fabric partner
    fifo_ports i_dut
    (
        .CLK(clk), .RSTN(rstn), .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready),
        .WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid), .WREADY(wready), .BRESP(bresp),
        .BVALID(bvalid), .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid),
        .ARREADY(arready), .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready),
        .RESET(reset), .WRITE_DATA(write_data), .WRITE_PARITY_IN(write_parity),
        .WRITE_REQUEST(write_request), .READ_REQUEST(read_request), .READ_DATA(read_data),
        .READ_PARITY_OUT(read_parity_out), .EMPTY(empty), .FULL(full),
        .ALMOST_EMPTY_FLAG(ae), .ALMOST_FULL_FLAG(af), .READ_SIDE_COUNT(count),
        .READ_ERROR(read_error), .WRITE_ERROR(write_error), .READ_RESET_BUSY(busy),
        .WRITE_RESET_BUSY(wbusy), .IRQ(irq)
    );
    fifo_user_model i_user
    (
        .clk(clk), .write_request(write_request), .read_request(read_request),
        .reset(reset), .write_data(write_data), .write_parity(write_parity)
    );

    // Clock
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task tick;
        @(posedge clk);
    endtask

    task check(input [31:0] seen, input [31:0] exp);
        begin
            samples_checked = samples_checked + 1;
            if (seen !== exp)
            begin
                num_errors = num_errors + 1;
                $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
            end
        end
    endtask

    task end_of_test;
        begin
            $display("checks %0d errors %0d", samples_checked, num_errors);
            if (num_errors == 0 && samples_checked > 0)
                $display("All tests passed");
            else
                $display("Some tests failed");
            $finish;
        end
    endtask

    // Bounded wait: sel 0 busy low, sel 1 interrupt high
    task wait_for(input sel);
        begin
            n = 0;
            while ((sel ? !irq : busy) !== 1'b0 && n < 20)
            begin
                tick;
                n = n + 1;
            end
            if (n == 20)
            begin
                num_errors = num_errors + 1;
                end_of_test;
            end
        end
    endtask

    // Register write, address and data offered together
    task axi_wr(input [7:0] a, input [31:0] v, input [3:0] s);
        begin
            awaddr <= a;
            wdata <= v;
            wstrb <= s;
            awvalid <= 1'b1;
            wvalid <= 1'b1;
            done = 1'b0;
            for (n = 0; n < 20 && !done; n = n + 1)
            begin
                tick;
                if (awready)
                begin
                    awvalid <= 1'b0;
                    bready <= 1'b1;
                end
                if (wready) wvalid <= 1'b0;
                if (bvalid)
                begin
                    check(bresp, 2'h0);
                    bready <= 1'b0;
                    done = 1'b1;
                end
            end
            if (!done)
            begin
                num_errors = num_errors + 1;
                end_of_test;
            end
        end
    endtask

    // Register read
    task axi_rd(input [7:0] a);
        begin
            araddr <= a;
            arvalid <= 1'b1;
            done = 1'b0;
            for (n = 0; n < 20 && !done; n = n + 1)
            begin
                tick;
                if (arready)
                begin
                    arvalid <= 1'b0;
                    rready <= 1'b1;
                end
                if (rvalid)
                begin
                    d = rdata;
                    r = rresp;
                    rready <= 1'b0;
                    done = 1'b1;
                end
            end
            if (!done)
            begin
                num_errors = num_errors + 1;
                end_of_test;
            end
        end
    endtask

    // Write refused while busy after reset
    task t_boot;
        begin
            tick;
            check(busy, 1'b1);
            check(wbusy, 1'b1);
            check(ae, 1'b1);
            i_user.put_burst(1, 32'h00000011, 4'h1);
            tick;
            check(write_error, 1'b1);
            check(count, 13'h0000);
            wait_for(1'b0);
        end
    endtask

    // Five words through, almost-empty edge, data order
    task t_basic;
        begin
            i_user.put_burst(4, 32'hA0000000, 4'h0);
            tick;
            check(count, 13'h0004);
            check(ae, 1'b1);
            check(empty, 1'b0);
            i_user.put_burst(1, 32'hA0000004, 4'h4);
            tick;
            check(ae, 1'b0);
            for (c = 0; c < 5; c = c + 1)
            begin
                i_user.take_burst(1);
                tick;
                check(read_data, 32'hA0000000 + c);
                check(read_parity_out, c);
            end
            check(empty, 1'b1);
            axi_rd(8'h00);
            check(d, 32'h00000001);
            axi_wr(8'h00, 32'h00000000, 4'hF);
            tick;
            check(count, 13'h0005);
            axi_wr(8'h00, 32'h00000001, 4'hF);
            axi_wr(8'h04, 32'h00000103, 4'h1);
            axi_rd(8'h04);
            check(d, 32'h00000003);
        end
    endtask

    // Every width code masks data and parity
    task t_width;
        begin
            for (c = 0; c < 4; c = c + 1)
            begin
                axi_wr(8'h00, (c << 1) | 1, 4'hF);
                i_user.put_burst(1, 32'hA5C35AF7, 4'hE);
                tick;
                i_user.take_burst(1);
                tick;
                check(read_data, 32'hA5C35AF7 & (32'hFFFFFFFF >> (32 - (32 >> c))));
                check(read_parity_out, 4'hE & (4'hF >> (4 - (4 >> c))));
            end
            axi_wr(8'h00, 32'h00000001, 4'hF);
        end
    endtask

    // Almost-full edge, full, refused write, drain
    task t_full;
        begin
            i_user.put_burst(507, 32'h00000000, 4'h0);
            tick;
            check(af, 1'b0);
            i_user.put_burst(1, 32'h000001FB, 4'h0);
            tick;
            check(af, 1'b1);
            i_user.put_burst(4, 32'h000001FC, 4'h0);
            tick;
            check(full, 1'b1);
            check(count, 13'h0200);
            i_user.put_burst(1, 32'hDEADBEEF, 4'h0);
            tick;
            check(write_error, 1'b1);
            check(count, 13'h0200);
            i_user.take_burst(512);
            tick;
            check(empty, 1'b1);
            check(read_data, 32'h000001FF);
        end
    endtask

    // Status, unmapped place, masked and cleared interrupt
    task t_irq;
        begin
            axi_rd(8'h0C);
            check(d, 32'h00000012);
            axi_rd(8'h20);
            check(r, 2'h2);
            check(irq, 1'b0);
            axi_wr(8'h14, 32'h00000001, 4'hF);
            axi_wr(8'h10, 32'h0000000F, 4'hF);
            i_user.take_burst(1);
            tick;
            check(read_error, 1'b1);
            wait_for(1'b1);
            axi_rd(8'h10);
            check(d[0], 1'b1);
            axi_wr(8'h10, 32'h00000001, 4'hF);
            tick;
            tick;
            check(irq, 1'b0);
        end
    endtask

    // Synchronous reset mid-run
    task t_sync;
        begin
            i_user.put_burst(2, 32'h00000055, 4'h5);
            i_user.pulse_reset;
            tick;
            check(busy, 1'b1);
            check(count, 13'h0000);
            i_user.take_burst(1);
            tick;
            check(read_error, 1'b1);
            wait_for(1'b0);
            i_user.put_burst(1, 32'h00000077, 4'h7);
            tick;
            i_user.take_burst(1);
            tick;
            check(read_data, 32'h00000077);
        end
    endtask

    // Main sequence
    initial
    begin
        num_errors = 0;
        samples_checked = 0;
        rstn = 1'b0;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        awaddr = 8'h00;
        araddr = 8'h00;
        wdata = 32'h00000000;
        wstrb = 4'hF;
        repeat (3) tick;
        rstn <= 1'b1;
        t_boot;
        t_basic;
        t_width;
        t_full;
        t_irq;
        t_sync;
        end_of_test;
    end
endmodule // tb_fifo_ports
